/* File: logic/audio_out_pkg.sv */
/*
 * audio_out_pkg: register map, field positions, reset values and timing
 * constants for the audio output path.
 * Assumes a 125 MHz system clock and byte-wide registers on a 32-bit bus.
 */
package audio_out_pkg;
	localparam int REG_COUNT = 16;
	localparam logic [11:0] REG_FIRST_INDEX = 12'h560;
	localparam logic [11:0] IDX_CONTROL = 12'h560;
	localparam logic [11:0] IDX_MIDPOINT = 12'h561;
	localparam logic [11:0] IDX_VOLUME = 12'h562;
	localparam logic [11:0] IDX_MODE = 12'h563;
	localparam logic [11:0] IDX_TUNE = 12'h564;
	localparam logic [11:0] IDX_DIV_STEP_LOW = 12'h565;
	localparam logic [11:0] IDX_STEP_MID = 12'h566;
	localparam logic [11:0] IDX_STEP_HIGH = 12'h567;
	localparam logic [11:0] IDX_NOISE_LEFT = 12'h568;
	localparam logic [11:0] IDX_NOISE_RIGHT = 12'h569;
	localparam logic [11:0] IDX_NOISE_R1_SWAP = 12'h56a;
	localparam logic [11:0] IDX_NOISE_R2_SEL = 12'h56b;
	localparam logic [11:0] IDX_CONST_L_LOW = 12'h56c;
	localparam logic [11:0] IDX_CONST_L_HIGH = 12'h56d;
	localparam logic [11:0] IDX_CONST_R_LOW = 12'h56e;
	localparam logic [11:0] IDX_CONST_R_HIGH = 12'h56f;
	// byte address is four times the index
	localparam int ADDR_W = 14;
	localparam logic [15:0][7:0] REG_RESET = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h40, 8'h50,
		8'h00, 8'hc4, 8'h90, 8'h01, 8'h64, 8'h40, 8'h40, 8'h04};
	localparam int CTRL_MONO = 0;
	localparam int CTRL_MOD_PLAYER = 2;
	localparam int CTRL_RECORDER = 4;
	localparam int CTRL_SERIAL_IF = 5;
	localparam int VOL_QUARTER = 0;
	localparam int VOL_HALF = 1;
	localparam int VOL_SHIFT_LSB = 2;
	localparam int VOL_SHIFT_MSB = 6;
	localparam int VOL_MUTE = 7;
	localparam int MODE_NO_DOUBLE = 0;
	localparam int MODE_PWM = 1;
	localparam int MODE_LINEAR = 2;
	localparam int MODE_SHAPE_LEFT = 5;
	localparam int MODE_SHAPE_RIGHT = 6;
	localparam int MODE_SERIAL_SWAP = 7;
	localparam int NOISE_BITS_MSB = 4;
	localparam int NOISE_EN_SECOND = 5;
	localparam int NOISE_EN_FIRST = 6;
	localparam int SWAP_MODULATORS = 5;
	localparam int CONST_SEL_LEFT = 5;
	localparam int CONST_SEL_RIGHT = 6;
	localparam int DIV_MSB = 3;
	localparam int STEP_LOW_LSB = 4;
	localparam int FRAC_W = 19;
	localparam logic [4:0] NOISE_BITS_MAX = 5'h10;
	localparam logic [15:0] LFSR_TAPS = 16'hb400;
	localparam logic [3:0][15:0] LFSR_SEED = {16'h9e37, 16'h5a3c, 16'hc1f5, 16'h2b71};
	localparam logic signed [21:0] FB_HIGH = 22'sh007fff;
	localparam logic signed [21:0] FB_LOW = -22'sh008000;
	localparam logic signed [15:0] SAT_MAX = 16'sh7fff;
	localparam logic signed [15:0] SAT_MIN = -16'sh8000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int SYS_CLOCK_MHZ = 125;
	localparam int MOD_CLOCK_MAX_MHZ = 8;
	// modulator tick divider, rounded up so the tick rate stays at or below the maximum
	localparam int MOD_DIV = (SYS_CLOCK_MHZ + MOD_CLOCK_MAX_MHZ - 1) / MOD_CLOCK_MAX_MHZ;
	localparam logic [4:0] MOD_DIV_LAST = 5'(MOD_DIV - 1);
	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,
		WR_RESPOND = 2'b10
	} wr_state_e;
endpackage : audio_out_pkg

/* File: logic/audio_output_path.sv */
/*
 * audio_output_path: rate matcher, volume, dither and per-channel
 * sigma-delta / PWM modulators, with byte registers on AXI4-Lite.
 * Assumes samples arrive as a valid/ready stream in the clk_sys domain;
 * the modulator domain is a derived tick of clk_sys.
 */
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - rate matcher moves samples into modulator time
// - phase step ratio is step over 0x80000
// - step from high, middle bytes, upper nibble of low byte
// - tuning byte adds to the step
// - mode bit 2 picks linear or hold
// - sixteen-bit samples become one-bit streams
// - one dither source per channel at once
// - control bits: mono, players, recorder enables
// - control bits: serial interface, gain group, filter
// - volume: quarter, half, shift, mute
// - left dither constant when select bit set
// - right dither constant when select bit set
// - left noise shaped when mode bit 5
// - right noise shaped when mode bit 6
// - two noise generators per channel enabled
// - five-bit width per noise generator
// - swap bit exchanges modulator data
// - PWM output, optional no doubling
// - mode bit 7 swaps serial input channels
// - low nibble divides serial bit clock
// - gain group midpoint byte
module audio_output_path import audio_out_pkg::*; (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // async reset, high
	input wire logic [15:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [15:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic sample_valid, // sample pair offered
	input wire logic [15:0] sample_left, // left sample
	input wire logic [15:0] sample_right, // right sample
	output logic sample_ready, // matcher wants a sample
	output logic mod_out_left, // left one-bit stream
	output logic mod_out_right, // right one-bit stream
	output logic serial_bit_clock, // serial audio bit clock
	input wire logic serial_in_valid, // serial input word strobe
	input wire logic [15:0] serial_in_left, // serial input left
	input wire logic [15:0] serial_in_right, // serial input right
	output logic [15:0] record_left, // recorded left
	output logic [15:0] record_right, // recorded right
	output logic [7:0] path_enable, // control byte to other stages
	output logic [7:0] gain_group_midpoint // gain group midpoint
);
	typedef struct packed {
		wr_state_e wr_state;
		logic aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [7:0] w_byte;
		logic w_lane;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0][7:0] regs;
		logic [4:0] tick_cnt;
		logic [FRAC_W-1:0] phase;
		logic need_sample;
		logic [1:0][15:0] prev;
		logic [1:0][15:0] cur;
		logic [3:0][15:0] lfsr;
		logic [1:0][15:0] dith_prev;
		logic [1:0][21:0] integ;
		logic [15:0] pwm_cnt;
		logic [1:0] mod_out;
		logic [3:0] sclk_cnt;
		logic sclk;
		logic [1:0][15:0] rec;
	} state_s;

	state_s st;
	state_s next_st;

	function automatic logic [3:0] reg_slot(input logic [11:0] idx);
		reg_slot = 4'(idx - REG_FIRST_INDEX);
	endfunction : reg_slot

	function automatic logic mapped(input logic [ADDR_W-1:0] idx);
		mapped = idx >= ADDR_W'(REG_FIRST_INDEX) &&
			idx < ADDR_W'(REG_FIRST_INDEX) + ADDR_W'(REG_COUNT);
	endfunction : mapped

	function automatic logic [15:0] noise_part(input logic [15:0] lfsr_val,
			input logic [4:0] bits, input logic en);
		logic [4:0] n;
		n = (bits > NOISE_BITS_MAX) ? NOISE_BITS_MAX : bits;
		noise_part = en ? (lfsr_val & 16'((17'h1 << n) - 17'h1)) : 16'h0;
	endfunction : noise_part

	function automatic logic signed [15:0] saturate(input logic signed [55:0] v);
		if (v > 56'(SAT_MAX))
			saturate = SAT_MAX;
		else if (v < 56'(SAT_MIN))
			saturate = SAT_MIN;
		else
			saturate = 16'(v);
	endfunction : saturate

	logic [7:0] ctrl, vol, mode;
	logic [19:0] step;
	logic [20:0] phase_sum;
	logic tick, advance;
	logic [1:0][15:0] shaped_dither, dither, chan, voiced;
	logic [1:0] shape_en, const_sel, en_first, en_second;
	logic [1:0][15:0] const_val;
	logic [1:0][4:0] bits_first, bits_second;
	logic [1:0][15:0] pn_raw;

	always_comb begin
		ctrl = st.regs[reg_slot(IDX_CONTROL)];
		vol = st.regs[reg_slot(IDX_VOLUME)];
		mode = st.regs[reg_slot(IDX_MODE)];
		// step assembled, then tuned
		step = 20'({st.regs[reg_slot(IDX_STEP_HIGH)], st.regs[reg_slot(IDX_STEP_MID)],
			st.regs[reg_slot(IDX_DIV_STEP_LOW)][7:STEP_LOW_LSB]})
			+ 20'(st.regs[reg_slot(IDX_TUNE)]);
		tick = st.tick_cnt == MOD_DIV_LAST && ctrl[CTRL_MOD_PLAYER];
		phase_sum = 21'(st.phase) + 21'(step);
		advance = tick && phase_sum[20:FRAC_W] != 2'b00;
		const_sel = {st.regs[reg_slot(IDX_NOISE_R2_SEL)][CONST_SEL_RIGHT],
			st.regs[reg_slot(IDX_NOISE_R2_SEL)][CONST_SEL_LEFT]};
		shape_en = {mode[MODE_SHAPE_RIGHT], mode[MODE_SHAPE_LEFT]};
		const_val[0] = {st.regs[reg_slot(IDX_CONST_L_HIGH)], st.regs[reg_slot(IDX_CONST_L_LOW)]};
		const_val[1] = {st.regs[reg_slot(IDX_CONST_R_HIGH)], st.regs[reg_slot(IDX_CONST_R_LOW)]};
		en_first = {st.regs[reg_slot(IDX_NOISE_RIGHT)][NOISE_EN_FIRST],
			st.regs[reg_slot(IDX_NOISE_LEFT)][NOISE_EN_FIRST]};
		en_second = {st.regs[reg_slot(IDX_NOISE_RIGHT)][NOISE_EN_SECOND],
			st.regs[reg_slot(IDX_NOISE_LEFT)][NOISE_EN_SECOND]};
		bits_first[0] = st.regs[reg_slot(IDX_NOISE_LEFT)][NOISE_BITS_MSB:0];
		bits_second[0] = st.regs[reg_slot(IDX_NOISE_RIGHT)][NOISE_BITS_MSB:0];
		bits_first[1] = st.regs[reg_slot(IDX_NOISE_R1_SWAP)][NOISE_BITS_MSB:0];
		bits_second[1] = st.regs[reg_slot(IDX_NOISE_R2_SEL)][NOISE_BITS_MSB:0];
	end

	// per-channel datapath
	for (genvar c = 0; c < 2; c++) begin : g_chan
		logic signed [16:0] diff;
		logic signed [37:0] prod;
		logic signed [18:0] scaled;
		logic signed [55:0] wide;
		always_comb begin
			diff = $signed({st.cur[c][15], st.cur[c]}) - $signed({st.prev[c][15], st.prev[c]});
			prod = 38'(diff * $signed({1'b0, st.phase}));
			// linear weights by phase, otherwise hold previous
			if (mode[MODE_LINEAR])
				chan[c] = 16'($signed(st.prev[c]) + 16'(prod >>> FRAC_W));
			else
				chan[c] = st.prev[c];
			scaled = 19'($signed(chan[c])) * 19'sd4
				+ (vol[VOL_HALF] ? 19'($signed(chan[c])) * 19'sd2 : 19'sd0)
				+ (vol[VOL_QUARTER] ? 19'($signed(chan[c])) : 19'sd0);
			wide = (56'(scaled) <<< vol[VOL_SHIFT_MSB:VOL_SHIFT_LSB]) >>> 2;
			voiced[c] = vol[VOL_MUTE] ? 16'h0 : saturate(wide);
			pn_raw[c] = noise_part(st.lfsr[2*c], bits_first[c], en_first[c])
				+ noise_part(st.lfsr[2*c+1], bits_second[c], en_second[c]);
			shaped_dither[c] = pn_raw[c] - st.dith_prev[c];
			// exactly one of constant, shaped or plain noise
			if (const_sel[c])
				dither[c] = const_val[c];
			else if (shape_en[c])
				dither[c] = shaped_dither[c];
			else
				dither[c] = pn_raw[c];
		end
	end

	always_comb begin
		logic [ADDR_W-1:0] ridx;
		logic [1:0][15:0] mod_in;
		logic [1:0][15:0] pwm_level;
		logic signed [21:0] fb;
		next_st = st;
		ridx = s_axi_araddr[ADDR_W+1:2];
		mod_in = '0;
		pwm_level = '0;
		fb = '0;
		// write channel: address and data in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_have = 1'b1;
			next_st.aw_addr = s_axi_awaddr[ADDR_W+1:2];
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_have = 1'b1;
			next_st.w_byte = s_axi_wdata[7:0];
			next_st.w_lane = s_axi_wstrb[0];
		end
		case (st.wr_state)
			WR_COLLECT: begin
				if (st.aw_have && st.w_have) begin
					next_st.aw_have = 1'b0;
					next_st.w_have = 1'b0;
					next_st.bvalid = 1'b1;
					next_st.wr_state = WR_RESPOND;
					if (mapped(st.aw_addr)) begin
						next_st.bresp = RESP_OKAY;
						if (st.w_lane)
							next_st.regs[4'(st.aw_addr - ADDR_W'(REG_FIRST_INDEX))] = st.w_byte;
					end else begin
						next_st.bresp = RESP_SLVERR;
					end
				end
			end
			WR_RESPOND: begin
				if (s_axi_bready) begin
					next_st.bvalid = 1'b0;
					next_st.wr_state = WR_COLLECT;
				end
			end
			default: next_st.wr_state = WR_COLLECT;
		endcase
		next_st.awready = !next_st.aw_have && next_st.wr_state == WR_COLLECT;
		next_st.wready = !next_st.w_have && next_st.wr_state == WR_COLLECT;
		// read channel
		if (s_axi_arvalid && st.arready) begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			if (mapped(ridx)) begin
				next_st.rdata = {24'h0, st.regs[4'(ridx - ADDR_W'(REG_FIRST_INDEX))]};
				next_st.rresp = RESP_OKAY;
			end else begin
				next_st.rdata = 32'h0;
				next_st.rresp = RESP_SLVERR;
			end
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
			next_st.arready = 1'b1;
		end
		// modulator tick derived from clk_sys
		next_st.tick_cnt = (st.tick_cnt == MOD_DIV_LAST) ? 5'h0 : 5'(st.tick_cnt + 5'h1);
		if (tick) begin
			next_st.phase = phase_sum[FRAC_W-1:0];
			for (int g = 0; g < 4; g++)
				next_st.lfsr[g] = {st.lfsr[g][14:0], ^(st.lfsr[g] & LFSR_TAPS)};
			next_st.dith_prev = pn_raw;
			next_st.pwm_cnt = 16'(st.pwm_cnt + 16'h1);
		end
		// new sample pair shifts in on phase wrap
		if (advance) begin
			next_st.prev = st.cur;
			next_st.need_sample = 1'b1;
		end
		if (sample_valid && st.need_sample) begin
			next_st.cur[0] = sample_left;
			next_st.cur[1] = ctrl[CTRL_MONO] ? sample_left : sample_right;
			next_st.need_sample = advance;
		end
		// channel exchange between modulators
		if (st.regs[reg_slot(IDX_NOISE_R1_SWAP)][SWAP_MODULATORS])
			mod_in = {voiced[0], voiced[1]};
		else
			mod_in = voiced;
		for (int c = 0; c < 2; c++) begin
			fb = st.mod_out[c] ? FB_HIGH : FB_LOW;
			// pwm level offset-binary, doubled unless bit 0 set
			pwm_level[c] = mode[MODE_NO_DOUBLE] ? {~mod_in[c][15], mod_in[c][14:0]}
				: {~mod_in[c][15], mod_in[c][14:0]} << 1;
			if (!ctrl[CTRL_MOD_PLAYER]) begin
				next_st.integ[c] = '0;
				next_st.mod_out[c] = 1'b0;
			end else if (tick && mode[MODE_PWM]) begin
				next_st.mod_out[c] = pwm_level[c] > st.pwm_cnt;
			end else if (tick) begin
				next_st.integ[c] = 22'($signed(st.integ[c]) + 22'($signed(mod_in[c]))
					+ 22'($signed(dither[c])) - fb);
				next_st.mod_out[c] = !next_st.integ[c][21];
			end
		end
		// serial bit clock divider
		if (ctrl[CTRL_SERIAL_IF]) begin
			if (st.sclk_cnt >= st.regs[reg_slot(IDX_DIV_STEP_LOW)][DIV_MSB:0]) begin
				next_st.sclk_cnt = 4'h0;
				next_st.sclk = !st.sclk;
			end else begin
				next_st.sclk_cnt = 4'(st.sclk_cnt + 4'h1);
			end
		end else begin
			next_st.sclk_cnt = 4'h0;
			next_st.sclk = 1'b0;
		end
		// serial recorder with optional channel swap
		if (ctrl[CTRL_RECORDER] && serial_in_valid) begin
			if (mode[MODE_SERIAL_SWAP]) begin
				next_st.rec[0] = serial_in_right;
				next_st.rec[1] = serial_in_left;
			end else begin
				next_st.rec[0] = serial_in_left;
				next_st.rec[1] = serial_in_right;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
			st.wr_state <= WR_COLLECT;
			st.awready <= 1'b1;
			st.wready <= 1'b1;
			st.arready <= 1'b1;
			st.regs <= REG_RESET;
			st.lfsr <= LFSR_SEED;
			st.need_sample <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bresp = st.bresp;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_arready = st.arready;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rvalid = st.rvalid;
	assign sample_ready = st.need_sample;
	assign mod_out_left = st.mod_out[0];
	assign mod_out_right = st.mod_out[1];
	assign serial_bit_clock = st.sclk;
	assign record_left = st.rec[0];
	assign record_right = st.rec[1];
	assign path_enable = st.regs[reg_slot(IDX_CONTROL)];
	assign gain_group_midpoint = st.regs[reg_slot(IDX_MIDPOINT)];
endmodule : audio_output_path

/* File: tb/audio_output_path_monitor.sv */
/*
 * audio_output_path_monitor: port-level assertions for the audio output path.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module audio_output_path_monitor import audio_out_pkg::*; (
	input wire logic clk_sys, // clock
	input wire logic sys_rst, // reset
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic [15:0] s_axi_araddr, // ar addr
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic [1:0] s_axi_rresp, // r resp
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic mod_out_left, // left stream
	input wire logic serial_bit_clock, // bit clock
	input wire logic [7:0] path_enable // control byte
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	logic rd_map;
	assign rd_map = (s_axi_araddr[15:6] == 10'h056);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid) else $error("late write answer");
	a_write_stand: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("late read answer");
	a_read_stand: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_read_mapped: assert property (s_axi_arvalid && s_axi_arready && rd_map
		|=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0) else $error("bad mapped read");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && !rd_map
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
	a_clock_idle: assert property (!path_enable[CTRL_SERIAL_IF] [*2]
		|-> !serial_bit_clock) else $error("bit clock while off");
	a_mod_idle: assert property (!path_enable[CTRL_MOD_PLAYER] [*2]
		|-> !mod_out_left) else $error("modulator output while off");
	a_mod_tick: assert property ($changed(mod_out_left)
		|=> (!path_enable[CTRL_MOD_PLAYER] || $stable(mod_out_left)) [*8])
		else $error("modulator changed off tick");
endmodule : audio_output_path_monitor

/* File: tb/audio_sample_source.sv */
/*
 * audio_sample_source: memory-side sample source on the valid/ready stream.
 * Assumes the bench sets the levels; slow adds a gap after each take.
 */
`timescale 1ns/1ps
module audio_sample_source (
	input wire logic clk_sys, // clock
	input wire logic sys_rst, // reset
	input wire logic sample_ready, // matcher wants a pair
	input wire logic slow, // pause after each take
	input wire logic [15:0] level_left, // left value to send
	input wire logic [15:0] level_right, // right value to send
	output logic sample_valid, // pair offered
	output logic [15:0] sample_left, // left sample
	output logic [15:0] sample_right, // right sample
	output logic [15:0] takes // pairs handed over
);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sample_valid <= 1'b0;
			sample_left <= 16'h0;
			sample_right <= 16'h0;
			takes <= 16'h0;
		end else if (sample_valid && sample_ready) begin
			takes <= takes + 16'h1;
			sample_valid <= !slow;
			// released lines show the inverse, not the old value
			sample_left <= slow ? ~level_left : level_left;
			sample_right <= slow ? ~level_right : level_right;
		end else if (!sample_valid) begin
			sample_valid <= 1'b1;
			sample_left <= level_left;
			sample_right <= level_right;
		end
	end
endmodule : audio_sample_source

/* File: tb/audio_output_path_tb_top.sv */
/*
 * audio_output_path_tb_top: self-checking bench for the audio output path.
 * Assumes the package constants and a 125 MHz clock.
 */
`timescale 1ns/1ps
module audio_output_path_tb_top import audio_out_pkg::*; ();
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, serial_in_valid = 1'b0, slow = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic sample_valid, sample_ready, mod_out_left, mod_out_right, serial_bit_clock;
	logic [15:0] serial_in_left = 16'h0, serial_in_right = 16'h0, level_left = 16'h0;
	logic [15:0] level_right = 16'h0, sample_left, sample_right, record_left, record_right, takes;
	logic [7:0] path_enable, gain_group_midpoint;
	int mismatches = 0;
	int comparisons = 0;
	audio_output_path dut_u (.*);
	audio_sample_source src_u (.*);
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_val
	task automatic cmp_range(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask : cmp_range
	task automatic guard(inout int n);
		n++;
		if (n > 300) begin
			mismatches++;
			final_report();
		end
	endtask : guard
	task automatic reg_write(input logic [11:0] idx, input logic [7:0] d, input logic st,
		input logic [1:0] er);
		int n = 0;
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= {3'b000, st};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			guard(n);
		end while (s_axi_bvalid !== 1'b1);
		cmp_val({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : reg_write
	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		reg_write(idx, d, 1'b1, RESP_OKAY);
	endtask : wr
	task automatic rd_check(input logic [11:0] idx, input logic [7:0] e, input logic [1:0] er);
		int n = 0;
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			guard(n);
		end while (s_axi_rvalid !== 1'b1);
		cmp_val(s_axi_rdata, {24'h0, e});
		cmp_val({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd_check
	// ones among 128 modulator ticks, after settling
	task automatic density(output int l, output int r);
		l = 0;
		r = 0;
		repeat (512) @(posedge clk_sys);
		repeat (128) begin
			repeat (16) @(posedge clk_sys);
			l += (mod_out_left === 1'b1);
			r += (mod_out_right === 1'b1);
		end
	endtask : density
	task automatic t_registers();
		logic [7:0] rv [16] = '{8'h04, 8'h40, 8'h40, 8'h64, 8'h01, 8'h90, 8'hc4, 8'h00,
			8'h50, 8'h40, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 16; i++) rd_check(12'h560 + 12'(i), rv[i], RESP_OKAY);
		cmp_val(32'(path_enable), 32'h04);
		for (int i = 0; i < 16; i++) wr(12'h560 + 12'(i), 8'h5a ^ 8'(i));
		for (int i = 0; i < 16; i++) rd_check(12'h560 + 12'(i), 8'h5a ^ 8'(i), RESP_OKAY);
		cmp_val(32'(path_enable), 32'h5a);
		cmp_val(32'(gain_group_midpoint), 32'h5b);
		reg_write(IDX_CONTROL, 8'hff, 1'b0, RESP_OKAY);
		rd_check(IDX_CONTROL, 8'h5a, RESP_OKAY);
		reg_write(12'h570, 8'h11, 1'b1, RESP_SLVERR);
		rd_check(12'h55f, 8'h00, RESP_SLVERR);
		wr(IDX_CONTROL, 8'h04);
		wr(IDX_MODE, 8'h04);
		wr(IDX_VOLUME, 8'h00);
		wr(IDX_TUNE, 8'h00);
		wr(IDX_DIV_STEP_LOW, 8'h00);
		wr(IDX_STEP_MID, 8'h00);
		wr(IDX_STEP_HIGH, 8'h40);
		for (int i = 8; i < 16; i++) wr(12'h560 + 12'(i), (i == 11) ? 8'h60 : 8'h00);
	endtask : t_registers
	task automatic t_levels();
		int l;
		int r;
		level_left <= 16'h7fff;
		level_right <= 16'h8000;
		density(l, r);
		cmp_range(l, 124, 128);
		cmp_range(r, 0, 4);
		wr(IDX_NOISE_R1_SWAP, 8'h20);
		density(l, r);
		cmp_range(l, 0, 4);
		cmp_range(r, 124, 128);
		wr(IDX_NOISE_R1_SWAP, 8'h00);
		wr(IDX_CONTROL, 8'h05);
		density(l, r);
		cmp_range(r, 124, 128);
		wr(IDX_CONTROL, 8'h04);
	endtask : t_levels
	task automatic t_volume();
		int l;
		int r;
		level_left <= 16'h4000;
		level_right <= 16'h0000;
		for (int i = 0; i < 4; i++) begin
			wr(IDX_VOLUME, 8'(i));
			density(l, r);
			cmp_range(l, 93 + 8 * i, 99 + 8 * i);
		end
		wr(IDX_VOLUME, 8'h04);
		density(l, r);
		cmp_range(l, 124, 128);
		wr(IDX_VOLUME, 8'h80);
		wr(IDX_CONST_L_HIGH, 8'h40);
		wr(IDX_CONST_R_HIGH, 8'hc0);
		density(l, r);
		cmp_range(l, 93, 99);
		cmp_range(r, 29, 35);
		wr(IDX_NOISE_R2_SEL, 8'h00);
		density(l, r);
		cmp_range(l, 61, 67);
		cmp_range(r, 61, 67);
	endtask : t_volume
	task automatic t_rate();
		logic [15:0] t0;
		slow <= 1'b1;
		for (int i = 1; i < 3; i++) begin
			wr(IDX_STEP_HIGH, 8'(8'h10 * i));
			repeat (64) @(posedge clk_sys);
			t0 = takes;
			repeat (1600) @(posedge clk_sys);
			cmp_range(int'(takes - t0), 12 * i, 13 * i + 1);
		end
		slow <= 1'b0;
	endtask : t_rate
	task automatic t_bit_clock();
		int n;
		logic b;
		for (int d = 0; d < 4; d += 3) begin
			wr(IDX_DIV_STEP_LOW, 8'(d));
			wr(IDX_CONTROL, 8'h24);
			n = 0;
			b = serial_bit_clock;
			while (serial_bit_clock === b) begin
				@(posedge clk_sys);
				guard(n);
			end
			n = 0;
			b = serial_bit_clock;
			while (serial_bit_clock === b && n < 40) begin
				@(posedge clk_sys);
				n++;
			end
			cmp_val(32'(n), 32'(d + 1));
		end
		wr(IDX_CONTROL, 8'h14);
	endtask : t_bit_clock
	task automatic t_record();
		serial_in_left <= 16'h1234;
		serial_in_right <= 16'habcd;
		serial_in_valid <= 1'b1;
		repeat (4) @(posedge clk_sys);
		cmp_val(32'(record_left), 32'h1234);
		wr(IDX_MODE, 8'h84);
		repeat (4) @(posedge clk_sys);
		cmp_val(32'(record_left), 32'habcd);
		cmp_val(32'(record_right), 32'h1234);
		serial_in_valid <= 1'b0;
	endtask : t_record
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		t_registers();
		t_levels();
		t_volume();
		t_rate();
		t_bit_clock();
		t_record();
		final_report();
	end
endmodule : audio_output_path_tb_top
bind audio_output_path audio_output_path_monitor mon_u (.*);
